/* File: logic/pat_top.sv */
/*
 * paged translation and protection: takes a request from the core, walks
 * directory and table in memory, returns physical address, byte order and
 * fault. assumes memory answers each read with mem_rvalid, one request at a
 * time, and that the core holds req_valid until resp_valid.
 */
`timescale 1ns/1ns
`include "pat_params.svh"
module pat_top
    import pat_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic req_valid,
    input wire pat_req_s req,
    input wire logic trap_taken,
    input wire logic indirect_branch,
    input wire logic trap_bits_set,
    input wire logic control_register_store,
    input wire logic [2:0] cr_sel,
    input wire logic [31:0] cr_data,
    input wire logic mem_rvalid,
    input wire logic [31:0] mem_rdata,
    output logic mem_read_r,
    output logic [31:0] mem_addr_r,
    output logic mem_big_endian_r,
    output logic resp_valid_r,
    output pat_rsp_s resp_r,
    output logic io_allowed_r,
    output logic user_level_out_r,
    output logic translation_on_r
);
    ////////////////////////////////////////////////////////////////////////
    pat_state_e state_r, state_nxt;
    logic user_level, big_endian_select, wp, te;
    logic [19:0] directory_table_base;
    logic [31:0] vaddr, pde_r, combined;
    logic misalign, pde_fault, pte_fault, sel_fault;
    logic [31:0] paddr_nxt;

    pat_mode u_mode (
        .clock(clock),
        .rstn(rstn),
        .trap_taken(trap_taken),
        .indirect_branch(indirect_branch),
        .trap_bits_set(trap_bits_set),
        .control_register_store(control_register_store),
        .cr_sel(cr_sel),
        .cr_data(cr_data),
        .user_level_r(user_level),
        .previous_user_level_r(),
        .big_endian_select_r(big_endian_select),
        .write_protect_r(wp),
        .translation_enable_r(te),
        .directory_table_base_r(directory_table_base)
    );

    // RULE1 wrapping address sum
    function automatic logic [31:0] addr_add(input logic [31:0] a, input logic [31:0] b);
        logic [32:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[31:0];
    endfunction

    // RULE6 alignment by size
    function automatic logic is_misaligned(input logic [31:0] a, input pat_size_e sz);
        logic m;
        m = 1'b0;
        unique case (sz)
            PAT_SZ8: m = 1'b0;
            PAT_SZ16: m = a[0];
            PAT_SZ32: m = |a[1:0];
            PAT_SZ64: m = |a[2:0];
            PAT_SZ128: m = |a[3:0];
            default: m = 1'b1;
        endcase
        return m;
    endfunction

    assign vaddr = addr_add(req.vaddr, req.disp);
    assign misalign = !req.fetch && is_misaligned(vaddr, req.size);

    // RULE21 more restrictive of both
    assign combined = {mem_rdata[31:3], mem_rdata[2:0] & pde_r[2:0]};

    pat_check u_pde_chk (
        .entry(mem_rdata),
        .user_level(user_level),
        .write(req.write),
        .write_protect(wp),
        .fault(pde_fault)
    );
    pat_check u_pte_chk (
        .entry(combined),
        .user_level(user_level),
        .write(req.write),
        .write_protect(wp),
        .fault(pte_fault)
    );
    assign sel_fault = (state_r == PAT_PDE_W) ? pde_fault : pte_fault;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            PAT_IDLE: begin
                if (req_valid) begin
                    if (misalign || !te) begin
                        state_nxt = PAT_DONE;
                    end else begin
                        state_nxt = PAT_PDE;
                    end
                end
            end
            PAT_PDE: state_nxt = PAT_PDE_W;
            PAT_PDE_W: begin
                if (mem_rvalid) begin
                    // RULE22 large page ends walk
                    if (pde_fault || mem_rdata[`PAT_ENT_PS]) begin
                        state_nxt = PAT_DONE;
                    end else begin
                        state_nxt = PAT_PTE;
                    end
                end
            end
            PAT_PTE: state_nxt = PAT_PTE_W;
            PAT_PTE_W: begin
                if (mem_rvalid) begin
                    state_nxt = PAT_DONE;
                end
            end
            PAT_DONE: state_nxt = PAT_IDLE;
            default: state_nxt = PAT_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_r <= PAT_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            pde_r <= 32'h0000_0000;
        end else if (state_r == PAT_PDE_W && mem_rvalid) begin
            pde_r <= mem_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // table entry reads
    always_ff @(posedge clock) begin
        if (!rstn) begin
            mem_read_r <= 1'b0;
            mem_addr_r <= 32'h0000_0000;
            mem_big_endian_r <= 1'b0;
        end else begin
            // RULE4 entries little-endian
            mem_big_endian_r <= 1'b0;
            if (state_r == PAT_PDE) begin
                mem_read_r <= 1'b1;
                // RULE12 RULE9 RULE11 directory entry address
                mem_addr_r <= {directory_table_base, vaddr[31:22], 2'h0};
            end else if (state_r == PAT_PTE) begin
                mem_read_r <= 1'b1;
                // RULE10 table of 1K words
                mem_addr_r <= {pde_r[31:12], vaddr[21:12], 2'h0};
            end else begin
                mem_read_r <= 1'b0;
            end
        end
    end

    always_comb begin
        paddr_nxt = vaddr;
        if (te) begin
            if (state_r == PAT_PDE_W) begin
                // RULE22 RULE8 4M frame
                paddr_nxt = {mem_rdata[31:22], vaddr[21:0]};
            end else begin
                // RULE23 RULE8 4K frame
                paddr_nxt = {mem_rdata[31:12], vaddr[11:0]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fault is reported without side effects so the access can be retried
    always_ff @(posedge clock) begin
        if (!rstn) begin
            resp_valid_r <= 1'b0;
            resp_r <= '0;
        end else begin
            resp_valid_r <= 1'b0;
            if (state_r == PAT_IDLE && req_valid && (misalign || !te)) begin
                resp_valid_r <= 1'b1;
                resp_r.paddr <= paddr_nxt;
                // RULE3 RULE2 RULE5 byte order
                resp_r.big_endian <= !req.fetch && big_endian_select;
                resp_r.ifault <= 1'b0;
                resp_r.dfault <= misalign;
            end else if ((state_r == PAT_PDE_W || state_r == PAT_PTE_W) &&
                         state_nxt == PAT_DONE) begin
                resp_valid_r <= 1'b1;
                resp_r.paddr <= paddr_nxt;
                resp_r.big_endian <= !req.fetch && big_endian_select;
                // RULE24 fault class
                resp_r.ifault <= sel_fault && req.fetch;
                resp_r.dfault <= sel_fault && !req.fetch;
            end
        end
    end

    // RULE19 privileged io gating
    always_ff @(posedge clock) begin
        if (!rstn) begin
            io_allowed_r <= 1'b0;
            user_level_out_r <= 1'b0;
            translation_on_r <= 1'b0;
        end else begin
            io_allowed_r <= !user_level;
            user_level_out_r <= user_level;
            translation_on_r <= te;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    chk_align_dfault: assert property (@(posedge clock) disable iff (!rstn)
        state_r == PAT_IDLE && req_valid && misalign |=> resp_valid_r && resp_r.dfault)
        else $error("misaligned access not faulted"); // RULE6
    chk_fetch_little: assert property (@(posedge clock) disable iff (!rstn)
        state_r == PAT_IDLE && req_valid && req.fetch
        |-> ##[1:40] (resp_valid_r && !resp_r.big_endian))
        else $error("fetch used big-endian"); // RULE3
    chk_entry_little: assert property (@(posedge clock) disable iff (!rstn)
        mem_read_r |-> !mem_big_endian_r)
        else $error("entry read big-endian"); // RULE4
    chk_absent_faults: assert property (@(posedge clock) disable iff (!rstn)
        state_r == PAT_PDE_W && mem_rvalid && !mem_rdata[`PAT_ENT_P]
        |=> resp_valid_r && (resp_r.ifault || resp_r.dfault))
        else $error("absent entry not faulted"); // RULE13
    chk_user_io_off: assert property (@(posedge clock) disable iff (!rstn)
        user_level |=> !io_allowed_r)
        else $error("io allowed at user level"); // RULE19
    chk_big_page: assert property (@(posedge clock) disable iff (!rstn)
        state_r == PAT_PDE_W && mem_rvalid && te && !pde_fault && mem_rdata[`PAT_ENT_PS]
        |=> resp_r.paddr == {$past(mem_rdata[31:22]), $past(vaddr[21:0])})
        else $error("4M address wrong"); // RULE22
    chk_off_no_walk: assert property (@(posedge clock) disable iff (!rstn)
        !te && state_r == PAT_IDLE && req_valid |=> state_r == PAT_DONE && !mem_read_r)
        else $error("walk while translation off"); // RULE7
    cov_small_page: cover property (@(posedge clock) disable iff (!rstn)
        state_r == PAT_PTE_W && mem_rvalid && !pte_fault);
    cov_large_page: cover property (@(posedge clock) disable iff (!rstn)
        state_r == PAT_PDE_W && mem_rvalid && mem_rdata[`PAT_ENT_PS]);
    cov_misalign: cover property (@(posedge clock) disable iff (!rstn)
        state_r == PAT_IDLE && req_valid && misalign);
endmodule

/* File: include/pat_params.svh */
/*
 * constants for the paged address translation and protection block.
 * assumes a 32-bit core clocked at 125 MHz and 32-bit table entries in memory.
 */
// What this block does
// RULE1 - address sums are 32 bits, overflow wraps modulo four gigabytes
// RULE2 - data defaults little-endian; supervisor may select big-endian
// RULE3 - instruction fetches always little-endian
// RULE4 - directory and table entry accesses always little-endian
// RULE5 - data byte order also covers io load/store, int-ack and special cycles
// RULE6 - misaligned data access for its operand size raises a data-access trap
// RULE7 - translation off after reset; control store sets or clears the enable
// RULE8 - 4 Kbyte and 4 Mbyte pages, each aligned to its own size
// RULE9 - directory index picks entry; page field indexes table for 4K pages
// RULE10 - a page table is one 4 Kbyte page of 1K 32-bit entries
// RULE11 - directory entry points to a table or a 4 Mbyte frame
// RULE12 - directory base comes from the directory table base field
// RULE13 - entry not present faults and no other bit is tested
// RULE14 - a trap copies user level to previous user and enters supervisor
// RULE15 - indirect branch with trap bits set restores previous user level
// RULE16 - user access to supervisor-only page traps
// RULE17 - user write to non-writable page traps
// RULE18 - user control store to protected registers is ignored
// RULE19 - user io, special-cycle and int-ack instructions have no effect
// RULE20 - supervisor reads all; writes trap on read-only page only if protect set
// RULE21 - 4K page protection is the more restrictive of both entries
// RULE22 - directory bit 7 marks 4M page: 10-bit frame plus 22-bit offset
// RULE23 - 4K page: 20-bit table frame plus 12-bit offset
// RULE24 - fetch faults are instruction faults, others data faults, restartable
`ifndef PAT_PARAMS_SVH
`define PAT_PARAMS_SVH
`define PAT_ENT_P 0
`define PAT_ENT_W 1
`define PAT_ENT_U 2
`define PAT_ENT_PS 7
`define PAT_BASE_TE 5
`define PAT_BASE_LSB 12
`define PAT_CR_DIRBASE 3'h1
`define PAT_CR_EPSR 3'h2
`define PAT_CR_PSR 3'h3
`define PAT_PSR_PU 1
`define PAT_RST_BASE 32'h0000_0000
`define PAT_MEM_LAT_NS 8
`define PAT_MEM_LAT_CYC ((`PAT_MEM_LAT_NS + 7) / 8)
`endif

/* File: include/pat_pkg.sv */
/*
 * types shared by the translation block.
 * assumes the params header is included alongside.
 */
package pat_pkg;
    typedef enum logic [2:0] {
        PAT_IDLE = 3'b000,
        PAT_PDE = 3'b001,
        PAT_PDE_W = 3'b010,
        PAT_PTE = 3'b011,
        PAT_PTE_W = 3'b100,
        PAT_DONE = 3'b101
    } pat_state_e;
    typedef enum logic [2:0] {
        PAT_SZ8 = 3'h0,
        PAT_SZ16 = 3'h1,
        PAT_SZ32 = 3'h2,
        PAT_SZ64 = 3'h3,
        PAT_SZ128 = 3'h4
    } pat_size_e;
    typedef struct packed {
        logic [31:0] vaddr;
        logic [31:0] disp;
        logic fetch;
        logic write;
        logic io;
        pat_size_e size;
    } pat_req_s;
    typedef struct packed {
        logic [31:0] paddr;
        logic big_endian;
        logic ifault;
        logic dfault;
    } pat_rsp_s;
endpackage

/* File: logic/pat_mode.sv */
/*
 * privilege and control state: user level, previous user, byte order,
 * write protect, translation enable and directory base.
 * assumes trap and branch strobes are one-cycle pulses from the core.
 */
`timescale 1ns/1ns
`include "pat_params.svh"
module pat_mode
    import pat_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic trap_taken,
    input wire logic indirect_branch,
    input wire logic trap_bits_set,
    input wire logic control_register_store,
    input wire logic [2:0] cr_sel,
    input wire logic [31:0] cr_data,
    output logic user_level_r,
    output logic previous_user_level_r,
    output logic big_endian_select_r,
    output logic write_protect_r,
    output logic translation_enable_r,
    output logic [19:0] directory_table_base_r
);
    logic st_ok;
    // RULE18 protected stores
    assign st_ok = control_register_store && !user_level_r;

    // RULE14 trap entry
    always_ff @(posedge clock) begin
        if (!rstn) begin
            user_level_r <= 1'b0;
            previous_user_level_r <= 1'b0;
        end else if (trap_taken) begin
            previous_user_level_r <= user_level_r;
            user_level_r <= 1'b0;
        // RULE15 trap return
        end else if (indirect_branch && trap_bits_set) begin
            user_level_r <= previous_user_level_r;
        // supervisor seeds previous user so a trap return can enter user level
        end else if (st_ok && cr_sel == `PAT_CR_PSR) begin
            previous_user_level_r <= cr_data[`PAT_PSR_PU];
        end
    end

    // RULE7 enable and base
    always_ff @(posedge clock) begin
        if (!rstn) begin
            translation_enable_r <= 1'b0;
            directory_table_base_r <= 20'h0_0000;
        end else if (st_ok && cr_sel == `PAT_CR_DIRBASE) begin
            translation_enable_r <= cr_data[`PAT_BASE_TE];
            directory_table_base_r <= cr_data[31:`PAT_BASE_LSB];
        end
    end

    // RULE2 supervisor order select
    always_ff @(posedge clock) begin
        if (!rstn) begin
            big_endian_select_r <= 1'b0;
            write_protect_r <= 1'b0;
        end else if (st_ok && cr_sel == `PAT_CR_EPSR) begin
            big_endian_select_r <= cr_data[0];
            write_protect_r <= cr_data[1];
        end
    end

    chk_trap_enters_sup: assert property (@(posedge clock) disable iff (!rstn)
        trap_taken |=> !user_level_r && previous_user_level_r == $past(user_level_r))
        else $error("trap did not enter supervisor"); // RULE14
    chk_return_restores: assert property (@(posedge clock) disable iff (!rstn)
        !trap_taken && indirect_branch && trap_bits_set
        |=> user_level_r == $past(previous_user_level_r))
        else $error("return did not restore level"); // RULE15
    chk_user_store_ign: assert property (@(posedge clock) disable iff (!rstn)
        control_register_store && user_level_r
        |=> $stable(translation_enable_r) && $stable(big_endian_select_r))
        else $error("user store changed control"); // RULE18
    chk_enable_follows: assert property (@(posedge clock) disable iff (!rstn)
        control_register_store && !user_level_r && cr_sel == `PAT_CR_DIRBASE
        |=> translation_enable_r == $past(cr_data[`PAT_BASE_TE]))
        else $error("enable not updated"); // RULE7
    cov_trap_return: cover property (@(posedge clock) disable iff (!rstn)
        trap_taken ##[1:20] (indirect_branch && trap_bits_set));
endmodule

/* File: logic/pat_check.sv */
/*
 * protection check of one table entry against the access.
 * assumes combined attributes are presented when both levels are known.
 */
`timescale 1ns/1ns
`include "pat_params.svh"
module pat_check
    import pat_pkg::*;
(
    input wire logic [31:0] entry,
    input wire logic user_level,
    input wire logic write,
    input wire logic write_protect,
    output logic fault
);
    always_comb begin
        // RULE13 present first
        if (!entry[`PAT_ENT_P]) begin
            fault = 1'b1;
        // RULE16 supervisor-only page
        end else if (user_level && !entry[`PAT_ENT_U]) begin
            fault = 1'b1;
        // RULE17 RULE20 read-only page write
        end else if (write && !entry[`PAT_ENT_W] && (user_level || write_protect)) begin
            fault = 1'b1;
        end else begin
            fault = 1'b0;
        end
    end
endmodule

/* File: dv/pat_mem.sv */
/*
 * behavioural memory holding directory and table entries for the walk.
 * assumes one read in flight; entries are loaded by the bench into ent.
 */
`timescale 1ns/1ns
module pat_mem (
    input wire logic clock,
    input wire logic rstn,
    input wire logic mem_read_r,
    input wire logic [31:0] mem_addr_r,
    input wire logic slow,
    output logic mem_rvalid,
    output logic [31:0] mem_rdata
);
    logic [31:0] ent [logic [31:0]];
    logic [31:0] a;
    initial begin
        mem_rvalid = 1'b0;
        mem_rdata = 32'h5a5a_5a5a;
    end
    ////////////////////////////////////////////////////////////////
    // whole 32-bit words
    always @(posedge clock) begin
        if (rstn === 1'b1 && mem_read_r === 1'b1) begin
            a = mem_addr_r;
            repeat (slow ? 4 : 1) @(posedge clock);
            #1;
            mem_rvalid = 1'b1;
            // unloaded words read as not present
            mem_rdata = ent.exists(a) ? ent[a] : 32'hffff_fffe;
            @(posedge clock);
            #1;
            mem_rvalid = 1'b0;
            // released data must not keep looking valid
            mem_rdata = ~mem_rdata;
        end
    end
endmodule

/* File: dv/tb.sv */
/*
 * self-checking bench for the translation block with a memory model.
 * assumes user level is reached by seeding previous user and then
 * returning from a trap.
 */
`timescale 1ns/1ns
module tb;
    import pat_pkg::*;
    localparam logic [31:0] BASE = 32'h0010_0000;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic req_valid = 1'b0;
    logic trap_taken = 1'b0;
    logic indirect_branch = 1'b0;
    logic trap_bits_set = 1'b0;
    logic control_register_store = 1'b0;
    logic slow = 1'b0;
    logic [2:0] cr_sel = 3'h0;
    logic [31:0] cr_data = 32'h0;
    pat_req_s req = '0;
    logic mem_rvalid, mem_read_r, mem_big_endian_r, resp_valid_r, io_allowed_r;
    logic user_level_out_r, translation_on_r;
    logic [31:0] mem_rdata, mem_addr_r, va, pte_a;
    pat_rsp_s resp_r;
    logic [34:0] expq[$];
    logic [34:0] mskq[$];
    logic [34:0] e, m;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 87;

    always #4 clock = ~clock;

    pat_top pat_top_i (.clock(clock), .rstn(rstn), .req_valid(req_valid), .req(req),
        .trap_taken(trap_taken), .indirect_branch(indirect_branch),
        .trap_bits_set(trap_bits_set), .control_register_store(control_register_store),
        .cr_sel(cr_sel), .cr_data(cr_data), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
        .mem_read_r(mem_read_r), .mem_addr_r(mem_addr_r), .mem_big_endian_r(mem_big_endian_r),
        .resp_valid_r(resp_valid_r), .resp_r(resp_r), .io_allowed_r(io_allowed_r),
        .user_level_out_r(user_level_out_r), .translation_on_r(translation_on_r));
    pat_mem pat_mem_i (.clock(clock), .rstn(rstn), .mem_read_r(mem_read_r),
        .mem_addr_r(mem_addr_r), .slow(slow), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

    task automatic conclude;
        // a response still owed at the end means a hung or lost walk
        if (expq.size() != 0) begin
            errors++;
        end
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [34:0] seen, input logic [34:0] ex);
        total_checks++;
        if (seen !== ex) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
        end
    endtask

    ////////////////////////////////////////////////////////////////
    // one request held until answered; fault cases compare fault bits only
    task automatic xl(input logic [31:0] v, input logic [31:0] d, input logic f,
        input logic w, input logic io, input pat_size_e sz, input logic [31:0] pa,
        input logic be, input logic [1:0] flt);
        int n;
        expq.push_back({pa, be, flt});
        mskq.push_back(flt != 2'b00 ? 35'h3 : {35{1'b1}});
        req = '{vaddr: v, disp: d, fetch: f, write: w, io: io, size: sz};
        req_valid = 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (resp_valid_r !== 1'b1 && n < 50);
        if (resp_valid_r !== 1'b1) begin
            errors++;
        end
        @(posedge clock);
        #1;
        req_valid = 1'b0;
        @(posedge clock);
        #1;
    endtask

    task automatic cr(input logic [2:0] s, input logic [31:0] d);
        control_register_store = 1'b1;
        cr_sel = s;
        cr_data = d;
        @(posedge clock);
        #1;
        control_register_store = 1'b0;
        repeat (2) @(posedge clock);
        #1;
    endtask

    function automatic logic [31:0] pde_a(input logic [31:0] v);
        return {BASE[31:12], v[31:22], 2'b00};
    endfunction

    ////////////////////////////////////////////////////////////////
    // sampled mid-cycle, where the one-cycle response has settled
    always @(negedge clock) begin
        cycles++;
        if (cycles > 20000) begin
            errors++;
            conclude();
        end
        if (resp_valid_r === 1'b1) begin
            if (expq.size() == 0) begin
                chk("unexpected response", 35'h1, 35'h0);
            end else begin
                e = expq.pop_front();
                m = mskq.pop_front();
                chk("response", resp_r & m, e & m);
            end
        end
    end

    initial begin
        repeat (2) @(posedge clock);
        #1;
        rstn = 1'b1;
        @(posedge clock);
        #1;
        chk("translation after reset", translation_on_r, 0);
        chk("level after reset", user_level_out_r, 0);
        chk("walk order", mem_big_endian_r, 0);
        $display("test reset done");
        xl(32'hffff_fff0, 32'h20, 0, 0, 0, PAT_SZ32, 32'h10, 0, 2'b00);
        xl(32'h110, 0, 0, 0, 0, PAT_SZ128, 32'h110, 0, 2'b00);
        for (int s = 1; s < 5; s++) begin
            xl(32'h100 + (1 << (s - 1)), 0, 0, 0, 0, pat_size_e'(s), 0, 0, 2'b01);
        end
        $display("test untranslated done");
        cr(3'h2, 32'h1);
        xl(32'h40, 0, 0, 0, 0, PAT_SZ32, 32'h40, 1, 2'b00);
        xl(32'h44, 0, 0, 1, 1, PAT_SZ32, 32'h44, 1, 2'b00);
        xl(32'h48, 0, 1, 0, 0, PAT_SZ32, 32'h48, 0, 2'b00);
        cr(3'h2, 32'h0);
        xl(32'h40, 0, 0, 0, 0, PAT_SZ32, 32'h40, 0, 2'b00);
        $display("test byte order done");
        cr(3'h1, BASE | 32'h20);
        chk("translation on", translation_on_r, 1);
        for (int i = 0; i < 2; i++) begin
            slow = i[0];
            va = $random(seed);
            pte_a = {20'h00200, va[21:12], 2'b00};
            pat_mem_i.ent[pde_a(va)] = 32'h0020_0007;
            pat_mem_i.ent[pte_a] = 32'h0345_6007;
            xl(va, 0, 0, 0, 0, PAT_SZ8, {20'h03456, va[11:0]}, 0, 2'b00);
            va = $random(seed);
            pat_mem_i.ent[pde_a(va)] = 32'ha940_0087;
            xl(va, 0, 0, 1, 0, PAT_SZ8, {10'h2a5, va[21:0]}, 0, 2'b00);
        end
        $display("test walks done");
        va = 32'h1234_5000;
        pat_mem_i.ent[pde_a(va)] = 32'hffff_fffe;
        xl(va, 0, 0, 0, 0, PAT_SZ32, 0, 0, 2'b01);
        xl(va, 0, 1, 0, 0, PAT_SZ32, 0, 0, 2'b10);
        pte_a = {20'h00200, va[21:12], 2'b00};
        pat_mem_i.ent[pde_a(va)] = 32'h0020_0007;
        pat_mem_i.ent[pte_a] = 32'hffff_fffe;
        xl(va, 0, 0, 0, 0, PAT_SZ32, 0, 0, 2'b01);
        $display("test not present done");
        pat_mem_i.ent[pte_a] = 32'h0345_6001;
        xl(va, 0, 0, 1, 0, PAT_SZ32, 32'h0345_6000, 0, 2'b00);
        cr(3'h2, 32'h2);
        xl(va, 0, 0, 1, 0, PAT_SZ32, 0, 0, 2'b01);
        xl(va, 0, 0, 0, 0, PAT_SZ32, 32'h0345_6000, 0, 2'b00);
        pat_mem_i.ent[pde_a(va)] = 32'h0020_0005;
        pat_mem_i.ent[pte_a] = 32'h0345_6007;
        xl(va, 0, 0, 1, 0, PAT_SZ32, 0, 0, 2'b01);
        $display("test protection done");
        trap_taken = 1'b1;
        @(posedge clock);
        #1;
        trap_taken = 1'b0;
        cr(3'h3, 32'h2);
        trap_bits_set = 1'b1;
        indirect_branch = 1'b1;
        @(posedge clock);
        #1;
        indirect_branch = 1'b0;
        trap_bits_set = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        chk("level after return", user_level_out_r, 1);
        chk("user io", io_allowed_r, 0);
        cr(3'h1, BASE);
        chk("user store", translation_on_r, 1);
        pat_mem_i.ent[pde_a(va)] = 32'h0020_0007;
        pat_mem_i.ent[pte_a] = 32'h0345_6005;
        xl(va, 0, 0, 0, 0, PAT_SZ32, 32'h0345_6000, 0, 2'b00);
        xl(va, 0, 0, 1, 0, PAT_SZ32, 0, 0, 2'b01);
        pat_mem_i.ent[pte_a] = 32'h0345_6003;
        xl(va, 0, 0, 0, 0, PAT_SZ32, 0, 0, 2'b01);
        xl(va, 0, 1, 0, 0, PAT_SZ32, 0, 0, 2'b10);
        trap_taken = 1'b1;
        @(posedge clock);
        #1;
        trap_taken = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        chk("level after trap", user_level_out_r, 0);
        chk("privileged io", io_allowed_r, 1);
        cr(3'h1, BASE);
        chk("translation off", translation_on_r, 0);
        xl(va, 0, 0, 1, 0, PAT_SZ32, va, 0, 2'b00);
        $display("test trap and disable done");
        conclude();
    end
endmodule
